/* rtl/pie_pkg.sv */
// Package for the peripheral interrupt enable bank
// Assumes a 32-bit classic Wishbone slave, byte addresses, 8-bit enable registers in the low lane, control mask at bits 9..8
package pie_pkg;
   localparam int unsigned  PIE_NREG      = 6;
   localparam int unsigned  PIE_AW        = 5;
   localparam logic [4:0]   PIE_OFF_EN1   = 5'h00;
   localparam logic [4:0]   PIE_OFF_EN2   = 5'h04;
   localparam logic [4:0]   PIE_OFF_EN3   = 5'h08;
   localparam logic [4:0]   PIE_OFF_EN4   = 5'h0c;
   localparam logic [4:0]   PIE_OFF_EN5   = 5'h10;
   localparam logic [4:0]   PIE_OFF_EN6   = 5'h14;
   localparam logic [4:0]   PIE_OFF_CTRL  = 5'h18;
   localparam logic [4:0]   PIE_OFF_STAT  = 5'h1c;
   // Writable masks (full-memory variant)
   localparam logic [7:0]   PIE_WM1       = 8'h7f;
   localparam logic [7:0]   PIE_WM2       = 8'hbf;
   localparam logic [7:0]   PIE_WM3       = 8'hcf;
   localparam logic [7:0]   PIE_WM4       = 8'hff;
   localparam logic [7:0]   PIE_WM5       = 8'hff;
   localparam logic [7:0]   PIE_WM6       = 8'h17;
   // Bits kept in the smaller-memory variant (cleared bits are absent)
   localparam logic [7:0]   PIE_SMALL_RM4 = 8'h3f;
   localparam logic [7:0]   PIE_SMALL_RM5 = 8'h17;
   localparam logic [7:0]   PIE_RST_EN    = 8'h00;
   // Control register fields
   localparam int unsigned  PIE_CTL_GRP   = 0;
   localparam int unsigned  PIE_CTL_PRIO  = 1;
   localparam int unsigned  PIE_CTL_WAVEB = 2;
   localparam int unsigned  PIE_CTL_NSTAT = 3;
   localparam int unsigned  PIE_CTL_IMSK  = 4;
   localparam int unsigned  PIE_DISP_BIT  = 6;
   localparam logic [3:0]   PIE_RST_CTL   = 4'h0;
   // Status event bits: 0 request rose, 1 write to a read-only enable
   localparam logic [1:0]   PIE_RST_ST    = 2'h0;
endpackage : pie_pkg

/* rtl/pie_enable_bank.sv */
// Peripheral interrupt enable bank with Wishbone register access
// Flags come latched from peripherals; the processor side does global gating
// Operation
// - Enable bit one passes its latched flag; zero masks it.
// - All enable bits clear to zero at reset.
// - Unimplemented bits ignore writes and read zero.
// - First register maps converter, serial1 rx/tx, sync port1, timer1 gate, timer2, timer1.
// - Second register maps osc fail, sync port2, collisions, voltage, timer3 ovf and gate.
// - Third register maps timer5 gate, display, serial2, charge, capcmp2/1, calendar.
// - Serial port 2 enable bits are read-only zero.
// - Display enable acts only in waveform B non-static mode.
// - Fourth register bits 7..0 enable capture/compare units 10..3.
// - Small variant lacks capture/compare 10 and 9 enables.
// - Fifth register maps timers 7g,12,10,8,7,6,5,4.
// - Small variant lacks timer 7 gate, 12, 10, 7 overflow enables.
// - Sixth register: bit 4 memory write done, bits 2..0 comparators.
// - Without priority scheme, group enable must be set for any request.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pie_enable_bank
   import pie_pkg::*;
#(
   parameter bit SMALL_MEM = 1'b0
)(
   // Clock and reset
   input  wire logic                  i_clock,
   input  wire logic                  i_resetn,
   // Wishbone slave
   input  wire logic                  i_wb_cyc,
   input  wire logic                  i_wb_stb,
   input  wire logic                  i_wb_we,
   input  wire logic [PIE_AW-1:0]     i_wb_adr,
   input  wire logic [3:0]            i_wb_sel,
   input  wire logic [31:0]           i_wb_dat,
   output logic      [31:0]           o_wb_dat,
   output logic                       o_wb_ack,
   // Latched peripheral flags, one byte per register
   input  wire logic [8*PIE_NREG-1:0] i_flags,
   // Requests
   output logic                       o_periph_req,
   output logic [8*PIE_NREG-1:0]      o_gated,
   output logic                       o_irq
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [8*PIE_NREG-1:0] en;
      logic [3:0]            ctl;
      logic [1:0]            st;
      logic [1:0]            msk;
      logic                  ack;
      logic [31:0]           dat;
      logic                  req;
      logic [8*PIE_NREG-1:0] gated;
   } pie_state_t;

   pie_state_t state_r;
   pie_state_t state_nxt;

   function automatic logic [7:0] pie_wmask(input int unsigned idx);
      logic [7:0] m;
      m = 8'h00;
      case (idx)
         0: m = PIE_WM1;
         1: m = PIE_WM2;
         2: m = PIE_WM3;
         3: m = SMALL_MEM ? (PIE_WM4 & PIE_SMALL_RM4) : PIE_WM4;
         4: m = SMALL_MEM ? (PIE_WM5 & PIE_SMALL_RM5) : PIE_WM5;
         5: m = PIE_WM6;
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [8*PIE_NREG-1:0] eff_en;
   logic                  req_c;
   logic                  access;
   logic                  ro_hit;
   int unsigned           ridx;
   logic [7:0]            wbyte;

   always_comb
   begin
      eff_en = state_r.en;
      if (!(state_r.ctl[PIE_CTL_WAVEB] && state_r.ctl[PIE_CTL_NSTAT]))
      begin
         eff_en[8*2+PIE_DISP_BIT] = 1'b0;
      end
   end

   assign access = i_wb_cyc & i_wb_stb & ~state_r.ack;
   assign ridx   = 32'(i_wb_adr[PIE_AW-1:2]);
   assign wbyte  = i_wb_dat[7:0];

   always_comb
   begin
      state_nxt       = state_r;
      ro_hit          = 1'b0;
      state_nxt.gated = i_flags & eff_en;
      req_c           = |(i_flags & eff_en);
      if (!state_r.ctl[PIE_CTL_PRIO] && !state_r.ctl[PIE_CTL_GRP])
      begin
         req_c = 1'b0;
      end
      state_nxt.req = req_c;
      state_nxt.ack = access;
      state_nxt.dat = 32'h0;
      if (access && !i_wb_we)
      begin
         if (ridx < PIE_NREG)
         begin
            state_nxt.dat[7:0] = state_r.en[8*ridx +: 8] & pie_wmask(ridx);
         end
         else if (i_wb_adr == PIE_OFF_CTRL)
         begin
            state_nxt.dat[3:0] = state_r.ctl;
            state_nxt.dat[9:8] = state_r.msk;
         end
         else if (i_wb_adr == PIE_OFF_STAT)
         begin
            state_nxt.dat[1:0] = state_r.st;
         end
      end
      // Write-one clears status; the hardware set below wins
      if (access && i_wb_we && i_wb_sel[0] && i_wb_adr == PIE_OFF_STAT)
      begin
         state_nxt.st = state_r.st & ~wbyte[1:0];
      end
      if (access && i_wb_we && i_wb_adr == PIE_OFF_CTRL)
      begin
         if (i_wb_sel[0])
         begin
            state_nxt.ctl = wbyte[3:0];
         end
         if (i_wb_sel[1])
         begin
            state_nxt.msk = i_wb_dat[9:8];
         end
      end
      // only enable bits change, flags are inputs untouched
      if (access && i_wb_we && i_wb_sel[0] && ridx < PIE_NREG)
      begin
         state_nxt.en[8*ridx +: 8] = wbyte & pie_wmask(ridx);
         if (ridx == 2 && (wbyte & ~PIE_WM3 & 8'h30) != 8'h00)
         begin
            ro_hit = 1'b1;
         end
      end
      if (req_c && !state_r.req)
      begin
         state_nxt.st[0] = 1'b1;
      end
      if (ro_hit)
      begin
         state_nxt.st[1] = 1'b1;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_r       <= '0;
         state_r.en    <= {PIE_NREG{PIE_RST_EN}};
         state_r.ctl   <= PIE_RST_CTL;
         state_r.st    <= PIE_RST_ST;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign o_wb_ack     = state_r.ack;
   assign o_wb_dat     = state_r.dat;
   assign o_periph_req = state_r.req;
   assign o_gated      = state_r.gated;
   assign o_irq        = |(state_r.st & state_r.msk);

   ////////////////////////////////////////////////////////////////////////
   // Reset and register contents
   a_reset_clear: assert property (@(posedge i_clock) $rose(i_resetn) |-> state_r.en == '0)
      else $error("enables not cleared at reset");

   a_unimpl_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_r.en[7] == 1'b0) && (state_r.en[14] == 1'b0) && (state_r.en[47:45] == 3'b000)
      && (state_r.en[43] == 1'b0))
      else $error("unimplemented enable bit set");

   a_ro_serial2: assert property (@(posedge i_clock) disable iff (!i_resetn)
      state_r.en[21:20] == 2'b00)
      else $error("serial 2 enable bits changed");

   a_small_var: assert property (@(posedge i_clock) disable iff (!i_resetn)
      SMALL_MEM |-> (state_r.en[31:30] == 2'b00) && (state_r.en[39:37] == 3'b000)
      && (state_r.en[35] == 1'b0))
      else $error("small variant bit set");

   a_en_hold: assert property (@(posedge i_clock) disable iff (!i_resetn)
      !(access && i_wb_we && i_wb_sel[0])
      |=> $stable(state_r.en))
      else $error("enables changed without a write");

   a_ctl_hold: assert property (@(posedge i_clock) disable iff (!i_resetn)
      !(access && i_wb_we && i_wb_adr == PIE_OFF_CTRL)
      |=> $stable(state_r.ctl))
      else $error("control changed without a write");

   a_write_en1: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && i_wb_we && i_wb_sel[0] && i_wb_adr == PIE_OFF_EN1)
      |=> state_r.en[7:0] == ($past(i_wb_dat[7:0]) & PIE_WM1))
      else $error("first enable write wrong");

   a_write_en2: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && i_wb_we && i_wb_sel[0] && i_wb_adr == PIE_OFF_EN2)
      |=> state_r.en[15:8] == ($past(i_wb_dat[7:0]) & PIE_WM2))
      else $error("second enable write wrong");

   a_write_en3: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && i_wb_we && i_wb_sel[0] && i_wb_adr == PIE_OFF_EN3)
      |=> state_r.en[23:16] == ($past(i_wb_dat[7:0]) & PIE_WM3))
      else $error("third enable write wrong");

   a_write_en: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && i_wb_we && i_wb_sel[0] && i_wb_adr == PIE_OFF_EN4 && !SMALL_MEM)
      |=> state_r.en[31:24] == $past(i_wb_dat[7:0]))
      else $error("enable write lost");

   a_write_en5: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && i_wb_we && i_wb_sel[0] && i_wb_adr == PIE_OFF_EN5 && !SMALL_MEM)
      |=> state_r.en[39:32] == ($past(i_wb_dat[7:0]) & PIE_WM5))
      else $error("fifth enable write wrong");

   a_write_en6: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && i_wb_we && i_wb_sel[0] && i_wb_adr == PIE_OFF_EN6)
      |=> state_r.en[47:40] == ($past(i_wb_dat[7:0]) & PIE_WM6))
      else $error("sixth enable write wrong");

   a_ro_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && i_wb_we && i_wb_sel[0] && i_wb_adr == PIE_OFF_EN3 && i_wb_dat[5:4] != 2'b00)
      |=> state_r.st[1])
      else $error("read-only write not flagged");

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake and read data
   a_ack_follow: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_wb_cyc && i_wb_stb && !o_wb_ack)
      |=> o_wb_ack)
      else $error("request not acknowledged");

   a_ack_pulse: assert property (@(posedge i_clock) disable iff (!i_resetn)
      o_wb_ack
      |=> !o_wb_ack)
      else $error("acknowledge held too long");

   a_dat_idle: assert property (@(posedge i_clock) disable iff (!i_resetn)
      !o_wb_ack
      |-> (o_wb_dat == 32'h0))
      else $error("read data outside acknowledge");

   a_rd_hi_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
      o_wb_ack
      |-> (o_wb_dat[31:10] == '0))
      else $error("upper read data not zero");

   a_rd_unimpl1: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && !i_wb_we && i_wb_adr == PIE_OFF_EN1)
      |=> (o_wb_dat[7] == 1'b0))
      else $error("first register bit 7 read one");

   a_rd_unimpl2: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && !i_wb_we && i_wb_adr == PIE_OFF_EN2)
      |=> (o_wb_dat[6] == 1'b0))
      else $error("second register bit 6 read one");

   a_rd_unimpl6: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && !i_wb_we && i_wb_adr == PIE_OFF_EN6)
      |=> (o_wb_dat[7:5] == 3'b000) && (o_wb_dat[3] == 1'b0))
      else $error("sixth register unused bits read one");

   a_rd_serial2: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (access && !i_wb_we && i_wb_adr == PIE_OFF_EN3)
      |=> (o_wb_dat[5:4] == 2'b00))
      else $error("serial 2 enables read one");

   a_rd_small: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (SMALL_MEM && access && !i_wb_we && i_wb_adr == PIE_OFF_EN4)
      |=> (o_wb_dat[7:6] == 2'b00))
      else $error("small variant unit bits read one");

   ////////////////////////////////////////////////////////////////////////
   // Gating, request and status
   a_gate_flag: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_flags[0] && state_r.en[0] && state_r.ctl[PIE_CTL_GRP])
      |=> o_periph_req)
      else $error("enabled flag did not raise request");

   a_flag_masked: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (i_flags[0] && !state_r.en[0])
      |=> !o_gated[0])
      else $error("disabled flag passed");

   a_gated_exact: assert property (@(posedge i_clock) disable iff (!i_resetn)
      1'b1
      |=> (o_gated == $past(i_flags & eff_en)))
      else $error("gated flags wrong");

   a_mask_all: assert property (@(posedge i_clock) disable iff (!i_resetn)
      ((i_flags & eff_en) == '0)
      |=> !o_periph_req)
      else $error("request without enabled flag");

   a_req_prio: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_r.ctl[PIE_CTL_PRIO] && ((i_flags & eff_en) != '0))
      |=> o_periph_req)
      else $error("request lost with priority scheme");

   a_group_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (!state_r.ctl[PIE_CTL_PRIO] && !state_r.ctl[PIE_CTL_GRP])
      |=> !o_periph_req)
      else $error("request passed with group disabled");

   a_display_gate: assert property (@(posedge i_clock) disable iff (!i_resetn)
      !state_r.ctl[PIE_CTL_WAVEB]
      |=> !o_gated[8*2+PIE_DISP_BIT])
      else $error("display request outside waveform B");

   a_display_on: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_r.ctl[PIE_CTL_WAVEB] && state_r.ctl[PIE_CTL_NSTAT] && i_flags[22] && state_r.en[22])
      |=> o_gated[8*2+PIE_DISP_BIT])
      else $error("display request blocked in waveform B");

   a_stat_rise: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (req_c && !state_r.req)
      |=> state_r.st[0])
      else $error("request rise not recorded");

   a_irq_masked: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_r.msk == 2'b00)
      |-> !o_irq)
      else $error("interrupt with all masked");
endmodule // pie_enable_bank
`default_nettype wire

/* verif/pie_flag_src.sv */
// Model of the latched peripheral flag sources
// Assumes the bench pulses set and clear masks for one cycle
`timescale 1ns/10ps
`default_nettype none
module pie_flag_src (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_resetn,
   // Events and software clears
   input  wire logic [47:0] i_set,
   input  wire logic [47:0] i_clr,
   // Latched flags
   output logic      [47:0] o_flags
);
   always_ff @(posedge i_clock or negedge i_resetn)
      if (!i_resetn)
         o_flags <= 48'h0;
      else
         o_flags <= (o_flags & ~i_clr) | i_set;
endmodule // pie_flag_src
`default_nettype wire

/* verif/pie_enable_bank_tb.sv */
// Bench for the enable bank: register access, flag gating, interrupt
// Assumes the flag source model and the design package
`timescale 1ns/10ps
`default_nettype none
module pie_enable_bank_tb;
   import pie_pkg::*;
   logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, req, irq;
   logic [4:0]  adr = '0;
   logic [3:0]  sel = '0;
   logic [31:0] dat = '0, rdat;
   logic [47:0] set = '0, clr = '0, fl, gtd, f, en;
   logic [7:0]  v;
   logic [7:0]  wm [6] = '{PIE_WM1, PIE_WM2, PIE_WM3, PIE_WM4, PIE_WM5, PIE_WM6};
   logic [31:0] expq [$], expq2 [$];
   logic        req2;
   logic [31:0] rdat2;
   logic [47:0] gtd2;
   localparam logic [47:0] SM = {8'hff, PIE_SMALL_RM5, PIE_SMALL_RM4, 24'hffffff};
   int          fail_count = 0, tests_run = 0;
   always #5 clk = ~clk;
   pie_flag_src src_u (.i_clock(clk), .i_resetn(rst_n), .i_set(set), .i_clr(clr), .o_flags(fl));
   pie_enable_bank dut_u (.i_clock(clk), .i_resetn(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_flags(fl),
      .o_periph_req(req), .o_gated(gtd), .o_irq(irq));
   pie_enable_bank #(.SMALL_MEM(1'b1)) dut_small_u (.i_clock(clk), .i_resetn(rst_n), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat2),
      .o_wb_ack(), .i_flags(fl), .o_periph_req(req2), .o_gated(gtd2), .o_irq());
   task automatic chk(input logic [47:0] e, input logic [47:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
         fail_count++;
      end
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         fail_count++;
         summarize();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      expq.push_back(e);
      expq2.push_back(e & {24'h0, (a == PIE_OFF_EN4) ? PIE_SMALL_RM4 : (a == PIE_OFF_EN5) ? PIE_SMALL_RM5 : 8'hff});
      wb(1'b0, a, 32'h0, 4'h1);
   endtask
   task automatic pulse(input logic [47:0] s, input logic [47:0] c);
      set <= s;
      clr <= c;
      @(posedge clk);
      set <= '0;
      clr <= '0;
      repeat (2) @(posedge clk);
   endtask
   // Read data watcher
   always @(posedge clk)
      if (ack === 1'b1 && we === 1'b0 && expq.size() > 0)
      begin
         chk({16'h0, expq.pop_front()}, {16'h0, rdat});
         chk({16'h0, expq2.pop_front()}, {16'h0, rdat2});
      end
   initial
   begin
      int k;
      void'($urandom(32'h9d41));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 8; k++)
         rd(5'(4 * k), 32'h0);
      for (k = 0; k < 12; k++)
      begin
         v = (k < 6) ? 8'($urandom) : 8'hff;
         wb(1'b1, 5'(4 * (k % 6)), {24'h0, v}, 4'h1);
         rd(5'(4 * (k % 6)), {24'h0, v & wm[k % 6]});
      end
      en = {wm[5], wm[4], wm[3], wm[2], wm[1], wm[0]};
      f = 48'({$urandom, $urandom}) | 48'h1;
      wb(1'b1, PIE_OFF_CTRL, 32'h1, 4'h1);
      pulse(f, '0);
      chk(f & en & ~(48'h1 << 22), gtd);
      chk(48'h1, {47'h0, req});
      chk(f & en & SM & ~(48'h1 << 22), gtd2);
      chk(48'h1, {47'h0, req2});
      wb(1'b1, PIE_OFF_CTRL, 32'hd, 4'h1);
      @(posedge clk);
      chk(f & en, gtd);
      wb(1'b1, PIE_OFF_CTRL, 32'h0, 4'h1);
      @(posedge clk);
      chk(48'h0, {47'h0, req});
      wb(1'b1, PIE_OFF_CTRL, 32'h2, 4'h1);
      @(posedge clk);
      chk(48'h1, {47'h0, req});
      wb(1'b1, PIE_OFF_EN1, 32'h0, 4'h1);
      @(posedge clk);
      chk(48'h0, {40'h0, gtd[7:0]});
      wb(1'b1, PIE_OFF_EN1, 32'h7f, 4'h1);
      @(posedge clk);
      chk({40'h0, f[7:0] & 8'h7f}, {40'h0, gtd[7:0]});
      pulse('0, '1);
      wb(1'b1, PIE_OFF_CTRL, 32'h1, 4'h3);
      wb(1'b1, PIE_OFF_STAT, 32'h3, 4'h1);
      pulse(48'h1, '0);
      chk(48'h0, {47'h0, irq});
      rd(PIE_OFF_STAT, 32'h1);
      wb(1'b1, PIE_OFF_CTRL, 32'h101, 4'h3);
      @(posedge clk);
      chk(48'h1, {47'h0, irq});
      wb(1'b1, PIE_OFF_STAT, 32'h1, 4'h1);
      @(posedge clk);
      chk(48'h0, {47'h0, irq});
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 6; k++)
         rd(5'(4 * k), 32'h0);
      summarize();
   end
endmodule // pie_enable_bank_tb
`default_nettype wire
